/* rtl/sfc_map.svh */
// Constants of the serial flash basic command unit
`ifndef SFC_MAP_SVH
`define SFC_MAP_SVH
`define SFC_OP_WREN 8'h06
`define SFC_OP_VWREN 8'h50
`define SFC_OP_WRDI 8'h04
`define SFC_OP_RDSR1 8'h05
`define SFC_OP_RDSR2 8'h35
`define SFC_OP_WRSR1 8'h01
`define SFC_OP_WRSR2 8'h31
`define SFC_OP_READ 8'h03
`define SFC_OP_FREAD 8'h0B
`define SFC_OP_DREAD 8'h3B
`define SFC_SR1_RESET 8'h00
`define SFC_SR2_RESET 8'h00
`define SFC_SR1_WMASK 8'hFC
`define SFC_SR2_WMASK 8'h7F
`define SFC_SR2_OTP_MASK 8'h3D
`define SFC_BIT_BUSY 0
`define SFC_BIT_WEL 1
`define SFC_ADDR_BITS 24
`define SFC_DUMMY_BITS 8
`define SFC_CLK_NS 50
`define SFC_TW_NS 10000000
`define SFC_TW_CYC ((`SFC_TW_NS + `SFC_CLK_NS - 1) / `SFC_CLK_NS)
`endif

/* rtl/sfc_pkg.sv */
// Types of the serial flash basic command unit
package sfc_pkg;
   typedef enum logic [2:0] {
      ST_OPCODE,
      ST_ADDR,
      ST_DUMMY,
      ST_DATA,
      ST_STAT,
      ST_WDATA,
      ST_IGNORE
   } sfc_state_t;

   typedef struct packed {
      logic cs_n;
      logic sck;
      logic mosi;
   } sfc_pins_t;

   typedef struct packed {
      logic mosi_o;
      logic mosi_oe;
      logic miso_o;
      logic miso_oe;
   } sfc_out_t;
endpackage : sfc_pkg

/* rtl/sfc_core.sv */
// Serial flash basic command unit: enables, status access and reads
`include "sfc_map.svh"
module sfc_core #(
   parameter int ADDR_W = 12,                      // Implemented array address width
   parameter int TW_CYC = `SFC_TW_CYC              // Status write time in cycles
) (
   input wire logic i_ref_clk,                     // System clock
   input wire logic i_rst_n,                       // Async reset, power-up
   input wire logic i_clk_en,                      // Freezes all state when low
   input wire logic i_cs_n,                        // Chip select pin, active low
   input wire logic i_sck,                         // Serial clock pin
   input wire logic i_line_zero,                   // Line zero input (serial_in)
   output logic o_line_zero,                       // Line zero output
   output logic o_line_zero_oe,                    // Line zero drive enable
   output logic o_line_one,                        // Line one output
   output logic o_line_one_oe,                     // Line one drive enable
   output logic o_busy,                            // Self-timed cycle running
   output logic o_write_enable_latch,              // Latch state
   output logic [7:0] o_status_reg_one,            // Status register one
   output logic [7:0] o_status_reg_two,            // Status register two
   output logic [ADDR_W-1:0] o_mem_addr,           // Array read address
   input wire logic [7:0] i_mem_data               // Array read data, same clock
);
   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [2:0] sync1_q, sync1_d, sync2_q, sync2_d;
   logic sck_prev_q, sck_prev_d;
   logic cs_prev_q, cs_prev_d;
   logic cs_n_s, sck_s, mosi_s, rise, fall, cs_rise;

   always_comb begin
      sync1_d = {i_cs_n, i_sck, i_line_zero};
      sync2_d = sync1_q;
      cs_n_s = sync2_q[2];
      sck_s = sync2_q[1];
      mosi_s = sync2_q[0];
      sck_prev_d = sck_s;
      cs_prev_d = cs_n_s;
      rise = !cs_n_s && sck_s && !sck_prev_q;
      fall = !cs_n_s && !sck_s && sck_prev_q;
      cs_rise = cs_n_s && !cs_prev_q;
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync1_q <= 3'h4;
         sync2_q <= 3'h4;
         sck_prev_q <= 1'b0;
         cs_prev_q <= 1'b1;
      end else if (i_clk_en) begin
         sync1_q <= sync1_d;
         sync2_q <= sync2_d;
         sck_prev_q <= sck_prev_d;
         cs_prev_q <= cs_prev_d;
      end
   end

   // ---------------------------------------------------------------
   // Frame engine
   // ---------------------------------------------------------------
   function automatic logic is_read(input logic [7:0] op);
      is_read = (op == `SFC_OP_READ) || (op == `SFC_OP_FREAD) || (op == `SFC_OP_DREAD);
   endfunction : is_read

   sfc_pkg::sfc_state_t st_q, st_d;
   logic [7:0] op_q, op_d, sh_q, sh_d, out_q, out_d, wd1_q, wd1_d;
   logic [4:0] cnt_q, cnt_d;
   logic [23:0] addr_q, addr_d;
   logic wel_q, wel_d, vol_q, vol_d, dual_q, dual_d;
   logic [7:0] sr1_q, sr1_d, sr2_q, sr2_d, nv1_q, nv1_d, nv2_q, nv2_d;
   logic [7:0] p1_q, p1_d, p2_q, p2_d;
   logic busy_q, busy_d;
   logic [31:0] tmr_q, tmr_d;
   logic [1:0] wcnt_q, wcnt_d;
   logic o0_q, o0_d, o0e_q, o0e_d, o1_q, o1_d, o1e_q, o1e_d;
   logic [7:0] b8;
   logic [7:0] st1_view;

   always_comb begin
      st_d = st_q;
      op_d = op_q;
      sh_d = sh_q;
      out_d = out_q;
      wd1_d = wd1_q;
      cnt_d = cnt_q;
      addr_d = addr_q;
      wel_d = wel_q;
      vol_d = vol_q;
      dual_d = dual_q;
      sr1_d = sr1_q;
      sr2_d = sr2_q;
      nv1_d = nv1_q;
      nv2_d = nv2_q;
      p1_d = p1_q;
      p2_d = p2_q;
      busy_d = busy_q;
      tmr_d = tmr_q;
      wcnt_d = wcnt_q;
      o0_d = o0_q;
      o0e_d = o0e_q;
      o1_d = o1_q;
      o1e_d = o1e_q;
      b8 = {sh_q[6:0], mosi_s};
      st1_view = {sr1_q[7:2], wel_q, busy_q};
      // Self-timed status write; latch clears when it ends
      if (busy_q) begin
         if (tmr_q <= 32'h0000_0001) begin
            busy_d = 1'b0;
            wel_d = 1'b0;
            nv1_d = p1_q;
            nv2_d = p2_q;
         end else begin
            tmr_d = tmr_q - 32'h0000_0001;
         end
      end
      if (rise) begin
         sh_d = b8;
         cnt_d = cnt_q + 5'h01;
         unique case (st_q)
            sfc_pkg::ST_OPCODE: begin
               if (cnt_q == 5'h07) begin
                  op_d = b8;
                  cnt_d = 5'h00;
                  st_d = sfc_pkg::ST_IGNORE;
                  dual_d = (b8 == `SFC_OP_DREAD);
                  if (b8 == `SFC_OP_RDSR1 || b8 == `SFC_OP_RDSR2) begin
                     st_d = sfc_pkg::ST_STAT;
                     out_d = (b8 == `SFC_OP_RDSR1) ? st1_view : sr2_q;
                  end else if (is_read(b8) && !busy_q) begin
                     st_d = sfc_pkg::ST_ADDR;
                  end else if ((b8 == `SFC_OP_WRSR1 || b8 == `SFC_OP_WRSR2) && !busy_q
                               && (wel_q || vol_q)) begin
                     st_d = sfc_pkg::ST_WDATA;
                     wcnt_d = 2'h0;
                  end
               end
            end
            sfc_pkg::ST_ADDR: begin
               addr_d = {addr_q[22:0], mosi_s};
               if (cnt_q == 5'(`SFC_ADDR_BITS - 1)) begin
                  cnt_d = 5'h00;
                  st_d = (op_q == `SFC_OP_READ) ? sfc_pkg::ST_DATA
                                                : sfc_pkg::ST_DUMMY;
               end
            end
            sfc_pkg::ST_DUMMY: begin
               if (cnt_q == 5'(`SFC_DUMMY_BITS - 1)) begin
                  cnt_d = 5'h00;
                  st_d = sfc_pkg::ST_DATA;
               end
            end
            sfc_pkg::ST_WDATA: begin
               if (cnt_q == 5'h07) begin
                  cnt_d = 5'h00;
                  if (wcnt_q == 2'h0) begin
                     wd1_d = b8;
                  end
                  wcnt_d = (wcnt_q == 2'h2) ? 2'h3 : wcnt_q + 2'h1;
               end
            end
            sfc_pkg::ST_DATA, sfc_pkg::ST_STAT, sfc_pkg::ST_IGNORE: begin
               cnt_d = (st_q == sfc_pkg::ST_IGNORE) ? 5'h01 : cnt_q;
            end
         endcase
      end
      if (fall) begin
         unique case (st_q)
            sfc_pkg::ST_STAT: begin
               o1e_d = 1'b1;
               o1_d = out_q[7];
               out_d = {out_q[6:0], out_q[7]};
               cnt_d = cnt_q + 5'h01;
               if (cnt_q == 5'h07) begin
                  cnt_d = 5'h00;
                  out_d = (op_q == `SFC_OP_RDSR1) ? st1_view : sr2_q;
               end
            end
            sfc_pkg::ST_DATA: begin
               if (cnt_q == 5'h00) begin
                  out_d = i_mem_data;
                  addr_d = addr_q + 24'h00_0001;
               end
               if (dual_q) begin
                  o0e_d = 1'b1;
                  o1e_d = 1'b1;
                  o1_d = (cnt_q == 5'h00) ? i_mem_data[7] : out_q[7];
                  o0_d = (cnt_q == 5'h00) ? i_mem_data[6] : out_q[6];
                  out_d = (cnt_q == 5'h00) ? {i_mem_data[5:0], 2'b00}
                                            : {out_q[5:0], 2'b00};
                  cnt_d = (cnt_q == 5'h03) ? 5'h00 : cnt_q + 5'h01;
               end else begin
                  o1e_d = 1'b1;
                  o1_d = (cnt_q == 5'h00) ? i_mem_data[7] : out_q[7];
                  out_d = (cnt_q == 5'h00) ? {i_mem_data[6:0], 1'b0}
                                            : {out_q[6:0], 1'b0};
                  cnt_d = (cnt_q == 5'h07) ? 5'h00 : cnt_q + 5'h01;
               end
            end
            default: begin
               o1e_d = o1e_q;
            end
         endcase
      end
      if (cs_rise) begin
         o0e_d = 1'b0;
         o1e_d = 1'b0;
         if (st_q == sfc_pkg::ST_IGNORE && cnt_q == 5'h00) begin
            // Exactly eight bits: any rise past the opcode has set the count
            unique case (op_q)
               `SFC_OP_WREN: wel_d = 1'b1;
               `SFC_OP_VWREN: vol_d = 1'b1;
               `SFC_OP_WRDI: begin
                  wel_d = 1'b0;
                  vol_d = 1'b0;
               end
               default: wel_d = wel_d;
            endcase
         end else if (st_q == sfc_pkg::ST_WDATA && cnt_q == 5'h00 &&
                      (wcnt_q == 2'h1 || (wcnt_q == 2'h2 && op_q == `SFC_OP_WRSR1))) begin
            // byte two only for the two-byte form
            p1_d = sr1_q;
            p2_d = sr2_q;
            if (op_q == `SFC_OP_WRSR1) begin
               p1_d = {(wd1_q[7:2] & 6'h3F), 2'b00};
               if (wcnt_q == 2'h2) begin
                  p2_d = (sh_q & `SFC_SR2_WMASK) | (sr2_q & `SFC_SR2_OTP_MASK);
               end
            end else begin
               p2_d = (wd1_q & `SFC_SR2_WMASK) | (sr2_q & `SFC_SR2_OTP_MASK);
            end
            sr1_d = p1_d;
            sr2_d = p2_d;
            if (vol_q && !wel_q) begin
               vol_d = 1'b0;
            end else begin
               busy_d = 1'b1;
               tmr_d = 32'(TW_CYC);
               vol_d = 1'b0;
            end
         end
         st_d = sfc_pkg::ST_OPCODE;
         cnt_d = 5'h00;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_q <= sfc_pkg::ST_OPCODE;
         op_q <= 8'h00;
         sh_q <= 8'h00;
         out_q <= 8'h00;
         wd1_q <= 8'h00;
         cnt_q <= 5'h00;
         addr_q <= 24'h00_0000;
         wel_q <= 1'b0;
         vol_q <= 1'b0;
         dual_q <= 1'b0;
         sr1_q <= `SFC_SR1_RESET;
         sr2_q <= `SFC_SR2_RESET;
         nv1_q <= `SFC_SR1_RESET;
         nv2_q <= `SFC_SR2_RESET;
         p1_q <= `SFC_SR1_RESET;
         p2_q <= `SFC_SR2_RESET;
         busy_q <= 1'b0;
         tmr_q <= 32'h0000_0000;
         wcnt_q <= 2'h0;
         o0_q <= 1'b0;
         o0e_q <= 1'b0;
         o1_q <= 1'b0;
         o1e_q <= 1'b0;
      end else if (i_clk_en) begin
         st_q <= st_d;
         op_q <= op_d;
         sh_q <= sh_d;
         out_q <= out_d;
         wd1_q <= wd1_d;
         cnt_q <= cnt_d;
         addr_q <= addr_d;
         wel_q <= wel_d;
         vol_q <= vol_d;
         dual_q <= dual_d;
         sr1_q <= sr1_d;
         sr2_q <= sr2_d;
         nv1_q <= nv1_d;
         nv2_q <= nv2_d;
         p1_q <= p1_d;
         p2_q <= p2_d;
         busy_q <= busy_d;
         tmr_q <= tmr_d;
         wcnt_q <= wcnt_d;
         o0_q <= o0_d;
         o0e_q <= o0e_d;
         o1_q <= o1_d;
         o1e_q <= o1e_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   always_comb begin
      o_line_zero = o0_q;
      o_line_zero_oe = o0e_q;
      o_line_one = o1_q;
      o_line_one_oe = o1e_q;
      o_busy = busy_q;
      o_write_enable_latch = wel_q;
      o_status_reg_one = {sr1_q[7:2], wel_q, busy_q};
      o_status_reg_two = sr2_q;
      o_mem_addr = addr_q[ADDR_W-1:0];
   end
endmodule : sfc_core

/* testbench/sfc_core_chk.sv */
// Port checker for the serial flash command unit
module sfc_core_chk #(
   parameter int ADDR_W = 12,
   parameter int TW_CYC = 20
) (
   input wire logic i_ref_clk, // Clock
   input wire logic i_rst_n, // Reset
   input wire logic i_clk_en, // Run
   input wire logic i_cs_n, // Select
   input wire logic i_sck, // Serial clock
   input wire logic i_line_zero, // Line zero in
   input wire logic o_line_zero, // Line zero out
   input wire logic o_line_zero_oe, // Line zero enable
   input wire logic o_line_one, // Line one out
   input wire logic o_line_one_oe, // Line one enable
   input wire logic o_busy, // Busy
   input wire logic o_write_enable_latch, // Latch
   input wire logic [7:0] o_status_reg_one, // Status one
   input wire logic [7:0] o_status_reg_two, // Status two
   input wire logic [ADDR_W-1:0] o_mem_addr, // Array address
   input wire logic [7:0] i_mem_data // Array data
);
   int busy_cnt_q;
   int busy_cnt_d;
   // ----------------------------------------
   // Busy length counter
   // ----------------------------------------
   always_comb begin
      // Frozen cycles do not count: the write timer stands with the enable
      busy_cnt_d = o_busy ? busy_cnt_q + int'(i_clk_en) : 0;
   end
   always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         busy_cnt_q <= 0;
      end else begin
         busy_cnt_q <= busy_cnt_d;
      end
   end
   default clocking cb @(posedge i_ref_clk);
   endclocking
   default disable iff (!i_rst_n);
   sequence busy_end_s;
      $fell(o_busy);
   endsequence
   // Enables may linger a few cycles after select rises
   sequence cs_idle_s;
      i_cs_n [*7];
   endsequence
   busy_len_a: assert property (busy_end_s |-> busy_cnt_q inside {[TW_CYC-1:TW_CYC+1]})
      else $error("busy length wrong");
   latch_end_a: assert property (busy_end_s |-> ##[0:2] !o_write_enable_latch)
      else $error("latch kept after busy");
   low_bits_a: assert property (o_status_reg_one[1:0] == {o_write_enable_latch, o_busy})
      else $error("status one low bits wrong");
   otp_keep_a: assert property (
      (($past(o_status_reg_two) & ~o_status_reg_two) & 8'h3d) == 8'h00)
      else $error("lock bit cleared");
   top_bit_a: assert property (o_status_reg_two[7] == 1'b0)
      else $error("status two bit 7 written");
   cs_quiet_a: assert property (cs_idle_s |-> !o_line_one_oe && !o_line_zero_oe)
      else $error("output driven without select");
   wr_latch_a: assert property ($rose(o_busy) |-> o_write_enable_latch)
      else $error("write cycle without latch");
   latch_set_a: assert property ($rose(o_write_enable_latch) |-> i_cs_n && !o_busy)
      else $error("latch set inside frame");
   dual_pair_a: assert property (o_line_zero_oe |-> o_line_one_oe)
      else $error("line zero driven alone");
   sr_frame_a: assert property (
      !$stable({o_status_reg_one[7:2], o_status_reg_two}) |-> i_cs_n)
      else $error("status changed mid frame");
endmodule : sfc_core_chk

bind sfc_core sfc_core_chk #(.ADDR_W(ADDR_W), .TW_CYC(TW_CYC)) u_sfc_core_chk (
   .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en), .i_cs_n(i_cs_n),
   .i_sck(i_sck), .i_line_zero(i_line_zero), .o_line_zero(o_line_zero),
   .o_line_zero_oe(o_line_zero_oe), .o_line_one(o_line_one), .o_line_one_oe(o_line_one_oe),
   .o_busy(o_busy), .o_write_enable_latch(o_write_enable_latch),
   .o_status_reg_one(o_status_reg_one), .o_status_reg_two(o_status_reg_two),
   .o_mem_addr(o_mem_addr), .i_mem_data(i_mem_data)
);

/* testbench/sfc_host.sv */
// Host controller model that frames serial transfers
module sfc_host (
   input wire logic i_clk, // Bench clock, frames start on its edge
   output logic o_cs_n, // Select
   output logic o_sck, // Serial clock
   output logic o_mosi, // Line zero drive
   output logic o_mosi_oe, // Line zero drive enable
   input wire logic i_lz, // Line zero wire
   input wire logic i_l1 // Line one wire
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      o_cs_n = 1'b1;
      o_sck = 1'b0;
      o_mosi = 1'b0;
      o_mosi_oe = 1'b0;
   end
   // Clock stands low outside frames; every change lands 7 ns after an edge
   task automatic frame(input logic [63:0] tx, input int ntx, input int nrx,
                        input bit dual, output logic [63:0] rx);
      rx = '0;
      @(posedge i_clk);
      #7 o_cs_n = 1'b0;
      o_mosi_oe = 1'b1;
      #200;
      for (int i = ntx - 1; i >= 0; i--) begin
         o_mosi = tx[i];
         #200 o_sck = 1'b1;
         if (dual && i == 0) o_mosi_oe = 1'b0;
         #200 o_sck = 1'b0;
      end
      for (int i = 0; i < nrx; i++) begin
         o_mosi = ~o_mosi;
         #200 o_sck = 1'b1;
         #190 rx = dual ? {rx[61:0], i_l1, i_lz} : {rx[62:0], i_l1};
         #10 o_sck = 1'b0;
      end
      #200 o_cs_n = 1'b1;
      o_mosi_oe = 1'b0;
      #400;
   endtask : frame
endmodule : sfc_host

/* testbench/sfc_core_tb_top.sv */
// Self-checking bench of the serial flash command unit
module sfc_core_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TW = 2000;
   logic i_ref_clk;
   logic i_rst_n;
   logic cs_n, sck, mosi, lz, oe_seen, host_oe, clk_en;
   logic lz_o, lz_oe, l1_o, l1_oe, busy, write_enable_latch;
   logic [7:0] sr1, sr2, mdat;
   logic [11:0] maddr;
   logic [63:0] rx;
   logic [7:0] ops [3];
   logic [7:0] exp_q[$];
   int mismatches, n_compared, m_sr1, m_sr2, m_wel, m_varm, m_busy;

   function automatic logic [7:0] mbyte(int a);
      return a[7:0] ^ a[11:4] ^ 8'h3c;
   endfunction : mbyte

   always #25 i_ref_clk = ~i_ref_clk;
   always @(posedge i_ref_clk) if (l1_oe === 1'b1) oe_seen <= 1'b1;
   // Released line shows the inverse of the last drive
   assign lz = lz_oe ? lz_o : (host_oe ? mosi : ~mosi);
   assign mdat = mbyte(int'(maddr));

   always @(posedge i_ref_clk) begin
      if (lz_oe === 1'b1 && host_oe === 1'b1) begin
         mismatches++;
         $display("[ERR] line_zero_owner expected 0 seen 1");
      end
   end

   sfc_core #(.ADDR_W(12), .TW_CYC(TW)) u_sfc_core (
      .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_clk_en(clk_en), .i_cs_n(cs_n),
      .i_sck(sck), .i_line_zero(lz), .o_line_zero(lz_o), .o_line_zero_oe(lz_oe),
      .o_line_one(l1_o), .o_line_one_oe(l1_oe), .o_busy(busy),
      .o_write_enable_latch(write_enable_latch), .o_status_reg_one(sr1), .o_status_reg_two(sr2),
      .o_mem_addr(maddr), .i_mem_data(mdat)
   );
   sfc_host u_sfc_host (
      .i_clk(i_ref_clk), .o_cs_n(cs_n), .o_sck(sck), .o_mosi(mosi), .o_mosi_oe(host_oe),
      .i_lz(lz), .i_l1(l1_o)
   );

   task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   task automatic close_out();
      if (mismatches == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : close_out

   function automatic logic [7:0] m_one();
      return {m_sr1[7:2], m_wel[0], m_busy[0]};
   endfunction : m_one

   task automatic regs();
      chk("sr1", m_one(), sr1);
      chk("sr2", m_sr2[7:0], sr2);
      chk("wel", {7'h00, m_wel[0]}, {7'h00, write_enable_latch});
   endtask : regs

   task automatic cmd(logic [7:0] op, int nbit);
      u_sfc_host.frame({56'h0, op} >> (8 - nbit), nbit, 0, 1'b0, rx);
      if (nbit == 8) begin
         if (op == 8'h06) m_wel = 1;
         if (op == 8'h50) m_varm = 1;
         if (op == 8'h04) {m_wel, m_varm} = '0;
      end
      regs();
   endtask : cmd

   // Write applies only with 8 bits, or 16 on register one
   task automatic wsr(logic [7:0] op, int nb, logic [15:0] d);
      u_sfc_host.frame({40'h0, op, d} >> (16 - nb), 8 + nb, 0, 1'b0, rx);
      if (m_busy == 0 && (m_wel | m_varm) != 0 && (nb == 8 || (nb == 16 && op == 8'h01))) begin
         if (op == 8'h01) m_sr1 = d[15:8];
         if (op == 8'h31) m_sr2 = (d[15:8] & 8'h7f) | (m_sr2 & 8'h3d);
         if (nb == 16) m_sr2 = (d[7:0] & 8'h7f) | (m_sr2 & 8'h3d);
         m_busy = m_wel;
         m_varm = 0;
      end
      regs();
   endtask : wsr

   task automatic srd(logic [7:0] op);
      logic [7:0] e;
      e = (op == 8'h05) ? m_one() : m_sr2[7:0];
      u_sfc_host.frame({56'h0, op}, 8, 16, 1'b0, rx);
      chk("stat_a", e, rx[15:8]);
      chk("stat_b", e, rx[7:0]);
   endtask : srd

   task automatic rd(logic [7:0] op, int a, int nb);
      int nd;
      nd = (op == 8'h03) ? 0 : 8;
      oe_seen = 1'b0;
      exp_q.delete();
      for (int k = 0; k < nb; k++) exp_q.push_back(mbyte(a + k));
      u_sfc_host.frame({24'h0, op, a[23:0], 8'h00} >> (8 - nd), 32 + nd,
                       (op == 8'h3b) ? nb * 4 : nb * 8, op == 8'h3b, rx);
      if (m_busy != 0) chk("rd_oe", 8'h00, {7'h00, oe_seen});
      for (int k = nb - 1; k >= 0 && m_busy == 0; k--) begin
         chk("rd", exp_q.pop_front(), rx[8*k +: 8]);
      end
   endtask : rd

   // Freezes the write cycle for 20 cycles, then waits for its end
   task automatic idle();
      clk_en = 1'b0;
      #1000;
      regs();
      clk_en = 1'b1;
      for (int k = 0; k < TW + 100 && busy !== 1'b0; k++) #50;
      chk("busy_end", 8'h00, {7'h00, busy});
      if (busy !== 1'b0) close_out();
      {m_busy, m_wel} = '0;
      #150;
      regs();
   endtask : idle

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      i_ref_clk = 1'b0;
      i_rst_n = 1'b0;
      oe_seen = 1'b0;
      clk_en = 1'b1;
      {mismatches, n_compared, m_sr1, m_sr2, m_wel, m_varm, m_busy} = '0;
      ops = '{8'h03, 8'h0b, 8'h3b};
      void'($urandom(36));
      repeat (2) @(posedge i_ref_clk);
      #7 i_rst_n = 1'b1;
      repeat (4) @(posedge i_ref_clk);
      regs();
      srd(8'h05);
      srd(8'h35);
      wsr(8'h01, 8, 16'hfc00);
      cmd(8'h06, 5);
      cmd(8'h06, 8);
      cmd(8'h50, 8);
      cmd(8'h04, 8);
      wsr(8'h01, 8, 16'h5400);
      cmd(8'h06, 8);
      wsr(8'h01, 9, 16'hffff);
      wsr(8'h01, 16, 16'($urandom));
      srd(8'h05);
      rd(8'h03, 0, 3);
      idle();
      cmd(8'h06, 8);
      wsr(8'h01, 8, 16'hffff);
      idle();
      cmd(8'h50, 8);
      wsr(8'h31, 8, 16'hff00);
      cmd(8'h50, 8);
      wsr(8'h31, 8, 16'h0000);
      for (int j = 0; j < 3; j++) begin
         rd(ops[j], (j == 0) ? 'hffe : $urandom, 3);
      end
      close_out();
   end
endmodule : sfc_core_tb_top
